//--- pwmp_pkg.sv
package pwmp_pkg;
    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] REG_CTRL_OFS  = 12'h000;
    localparam logic [ADDR_W-1:0] REG_PRESC_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] REG_DUTY_OFS  = 12'h008;
    localparam logic [ADDR_W-1:0] REG_STAT_OFS  = 12'h00c;
    // control field positions
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_CSS_BIT = 1;
    localparam int CTRL_PIN_BIT = 2;
    // status field positions
    localparam int STAT_RUN_BIT  = 0;
    localparam int STAT_LEAD_BIT = 1;
    localparam int STAT_LVL_BIT  = 2;
    // value widths and constants
    localparam int VAL_W  = 8;
    localparam int LEAD_W = 9;
    localparam logic [VAL_W-1:0]  VAL_ZERO   = 8'h00;
    localparam logic [VAL_W-1:0]  VAL_ONE    = 8'h01;
    localparam logic [VAL_W-1:0]  STEP_LAST  = 8'hfe;
    localparam logic [VAL_W-1:0]  DUTY_FULL  = 8'hff;
    localparam logic [VAL_W-1:0]  PRESC_RST  = 8'h00;
    localparam logic [VAL_W-1:0]  DUTY_RST   = 8'h00;
    localparam logic [LEAD_W-1:0] LEAD_ONE   = 9'h001;
    localparam logic [LEAD_W-1:0] LEAD_TWO   = 9'h002;
    localparam logic [LEAD_W-1:0] LEAD_ZERO  = 9'h000;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;
    // operating phases
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_RUN  = 2'b10
    } pwmp_state_type;
endpackage

//--- pwmp_core_if.sv
`timescale 1ns/1ps
`default_nettype none
// links the control logic to the two counter stages
interface pwmp_core_if;
    import pwmp_pkg::*;
    logic             run;        // counters active
    logic             src_sel;    // 1: full clock, 0: half clock
    logic [VAL_W-1:0] presc;      // active prescaler value
    logic [VAL_W-1:0] duty;       // active duty value
    logic             step_tick;  // one step of the 255-step period
    logic             level;      // raw compare result
    logic             period_end; // last step of a period done
    modport presc_mp (input run, input src_sel, input presc, output step_tick);
    modport wave_mp (input run, input duty, input step_tick, output level, output period_end);
endinterface
`default_nettype wire

//--- pwmp_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module pwmp_prescaler (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    pwmp_core_if.presc_mp   core
);
    import pwmp_pkg::*;

    logic [VAL_W-1:0] cnt_ff;  // counts source ticks 0..n
    logic             half_ff; // halves the clock

    // full rate when selected, else every second clock
    wire src_tick = core.src_sel | half_ff;
    wire cnt_end  = (cnt_ff == core.presc);
    // one step every n+1 source ticks
    assign core.step_tick = core.run & src_tick & cnt_end;

    // counters start from zero each time running begins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= VAL_ZERO;
            half_ff <= 1'b0;
        end else if (!core.run) begin
            cnt_ff  <= VAL_ZERO;
            half_ff <= 1'b0;
        end else begin
            half_ff <= ~half_ff;
            if (src_tick) begin
                cnt_ff <= cnt_end ? VAL_ZERO : cnt_ff + VAL_ONE;
            end
        end
    end

    a_step_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core.step_tick && core.presc != VAL_ZERO |=> !core.step_tick || !$stable(core.presc))
        else $error("prescaler step ticks too close");
    a_half_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core.run && !core.src_sel && half_ff |=> !half_ff)
        else $error("half rate source ticked twice");
endmodule
`default_nettype wire

//--- pwmp_wave.sv
`timescale 1ns/1ps
`default_nettype none
module pwmp_wave (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    pwmp_core_if.wave_mp    core
);
    import pwmp_pkg::*;

    logic [VAL_W-1:0] step_ff; // position 0..254 in the period

    // high while position is below duty; duty 0 never high
    assign core.level      = (step_ff < core.duty);
    assign core.period_end = core.step_tick & (step_ff == STEP_LAST);

    // 255 steps per period
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            step_ff <= VAL_ZERO;
        end else if (!core.run) begin
            step_ff <= VAL_ZERO;
        end else if (core.step_tick) begin
            step_ff <= core.period_end ? VAL_ZERO : step_ff + VAL_ONE;
        end
    end

    a_period_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core.run && core.period_end |=> step_ff == VAL_ZERO)
        else $error("period did not wrap after step 254");
    a_full_duty: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core.duty == DUTY_FULL |-> core.level)
        else $error("full duty gave a low step");
endmodule
`default_nettype wire

//--- pwmp_top.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - 8-bit duty; source clock or clock halved
// - control bit 2 picks pin a or b
// - period is 255 times (prescaler+1) source ticks
// - high time is period times duty/255
// - enable write restarts; first pulse starts high
// - new values apply from next period
// - low lead phase before first high pulse
module pwmp_top (
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pwmp_pkg::ADDR_W-1:0] paddr,
    input  wire logic [pwmp_pkg::DATA_W-1:0] pwdata,
    output var  logic [pwmp_pkg::DATA_W-1:0] prdata,
    output wire logic                       pready,
    output wire logic                       pslverr,
    output wire logic                       pulse_out_pin_a_o,
    output wire logic                       pulse_out_pin_a_oe,
    output wire logic                       pulse_out_pin_b_o,
    output wire logic                       pulse_out_pin_b_oe
);
    import pwmp_pkg::*;

    // reset release synchroniser
    logic [1:0] rst_sync_ff; // two stages
    logic       rst_n;       // synchronised reset

    // asserts at once, releases two edges later
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // software visible registers
    logic             en_ff;     // enable bit
    logic             css_ff;    // count source select
    logic             pinsel_ff; // output pin select
    logic [VAL_W-1:0] presc_ff;  // prescaler value as written
    logic [VAL_W-1:0] duty_ff;   // duty value as written

    // values in use by the running waveform
    logic             css_act_ff;
    logic [VAL_W-1:0] presc_act_ff;
    logic [VAL_W-1:0] duty_act_ff;

    // phase control
    pwmp_state_type    state_ff;   // current phase
    pwmp_state_type    nxt_state;  // next phase
    logic [LEAD_W-1:0] lead_cnt_ff; // clocks left in lead phase
    logic              out_level_ff; // registered pin level

    // bus decode
    wire sel_ctrl  = (paddr == REG_CTRL_OFS);
    wire sel_presc = (paddr == REG_PRESC_OFS);
    wire sel_duty  = (paddr == REG_DUTY_OFS);
    wire sel_stat  = (paddr == REG_STAT_OFS);
    wire addr_hit  = sel_ctrl | sel_presc | sel_duty | sel_stat;

    // every access completes in its first access cycle
    wire acc_phase = psel & penable;
    wire rd_setup  = psel & ~penable & ~pwrite;
    wire wr_en     = acc_phase & pwrite & addr_hit;
    wire wr_ctrl   = wr_en & sel_ctrl;
    wire wr_presc  = wr_en & sel_presc;
    wire wr_duty   = wr_en & sel_duty;

    assign pready  = 1'b1;
    // unmapped addresses answer with an error, nothing stored
    assign pslverr = acc_phase & ~addr_hit;

    // a write of 1 to enable restarts even when running
    wire start_wr = wr_ctrl & pwdata[CTRL_EN_BIT];
    wire stop_wr  = wr_ctrl & ~pwdata[CTRL_EN_BIT];

    // count source as it stands after this edge; a start write
    // carries its own select bit, and the copies must not see a stale one
    wire css_new  = wr_ctrl ? pwdata[CTRL_CSS_BIT] : css_ff;

    // phase decode
    wire in_idle = (state_ff == ST_IDLE);
    wire in_lead = (state_ff == ST_LEAD);
    wire in_run  = (state_ff == ST_RUN);

    // status word
    wire [DATA_W-1:0] stat_word = DATA_ZERO
        | (DATA_W'(in_run) << STAT_RUN_BIT)
        | (DATA_W'(in_lead) << STAT_LEAD_BIT)
        | (DATA_W'(out_level_ff) << STAT_LVL_BIT);

    // control word readback
    wire [DATA_W-1:0] ctrl_word = DATA_ZERO
        | (DATA_W'(en_ff) << CTRL_EN_BIT)
        | (DATA_W'(css_ff) << CTRL_CSS_BIT)
        | (DATA_W'(pinsel_ff) << CTRL_PIN_BIT);

    // read mux; unused upper bits read zero
    wire [DATA_W-1:0] rd_mux =
        sel_ctrl  ? ctrl_word :
        sel_presc ? DATA_W'(presc_ff) :
        sel_duty  ? DATA_W'(duty_ff) :
        sel_stat  ? stat_word : DATA_ZERO;

    // read data captured in setup so it comes from a flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= DATA_ZERO;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    // control register; reset leaves the modulator off
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            en_ff     <= 1'b0;
            css_ff    <= 1'b0;
            pinsel_ff <= 1'b0;
        end else if (wr_ctrl) begin
            en_ff     <= pwdata[CTRL_EN_BIT];
            css_ff    <= pwdata[CTRL_CSS_BIT];
            pinsel_ff <= pwdata[CTRL_PIN_BIT];
        end
    end

    // value registers; software may write them at any time
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff <= PRESC_RST;
            duty_ff  <= DUTY_RST;
        end else begin
            if (wr_presc) begin
                presc_ff <= pwdata[VAL_W-1:0];
            end
            if (wr_duty) begin
                duty_ff <= pwdata[VAL_W-1:0];
            end
        end
    end

    // counter stages
    pwmp_core_if core ();

    assign core.run     = in_run;
    assign core.src_sel = css_act_ff;
    assign core.presc   = presc_act_ff;
    assign core.duty    = duty_act_ff;

    pwmp_prescaler u_presc (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .core    (core.presc_mp)
    );

    pwmp_wave u_wave (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .core    (core.wave_mp)
    );

    // active values change at start or only on a period
    // boundary, so a half-done period never mixes settings
    wire load_act = start_wr | (in_run & core.period_end);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            css_act_ff   <= 1'b0;
            presc_act_ff <= PRESC_RST;
            duty_act_ff  <= DUTY_RST;
        end else if (load_act) begin
            css_act_ff   <= css_new;
            presc_act_ff <= presc_ff;
            duty_act_ff  <= duty_ff;
        end
    end

    // lead low length in clocks: n+1 at full rate,
    // (n+1)/2 rounded up at half rate
    wire [LEAD_W-1:0] presc_ext = {1'b0, presc_ff};
    wire [LEAD_W-1:0] lead_full = presc_ext + LEAD_ONE;
    wire [LEAD_W-1:0] lead_half = (presc_ext + LEAD_TWO) >> 1;
    wire [LEAD_W-1:0] lead_target = css_new ? lead_full : lead_half;
    wire              lead_done = in_lead & (lead_cnt_ff == LEAD_ONE);

    // next phase; a stop wins over everything, start restarts
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start_wr) begin
                    nxt_state = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (stop_wr) begin
                    nxt_state = ST_IDLE;
                end else if (start_wr) begin
                    nxt_state = ST_LEAD;
                end else if (lead_done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_wr) begin
                    nxt_state = ST_IDLE;
                end else if (start_wr) begin
                    nxt_state = ST_LEAD;
                end
            end
            default: begin
                nxt_state = ST_IDLE; // illegal code recovers
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // lead counter loaded on every start
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lead_cnt_ff <= LEAD_ZERO;
        end else if (start_wr) begin
            lead_cnt_ff <= lead_target;
        end else if (in_lead) begin
            lead_cnt_ff <= lead_cnt_ff - LEAD_ONE;
        end
    end

    // pin level registered; low in every phase but run.
    // a control write drops it at once, so a restart shows the
    // same low lead as a fresh start and a stop leaves no high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_level_ff <= 1'b0;
        end else begin
            out_level_ff <= in_run & ~wr_ctrl & core.level;
        end
    end

    // both pins carry the level; only the chosen one drives.
    // the pin is driven low during the lead phase as well
    assign pulse_out_pin_a_o  = out_level_ff;
    assign pulse_out_pin_b_o  = out_level_ff;
    assign pulse_out_pin_a_oe = en_ff & ~pinsel_ff;
    assign pulse_out_pin_b_oe = en_ff & pinsel_ff;

    a_oe_off_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_idle |-> !pulse_out_pin_a_oe && !pulse_out_pin_b_oe)
        else $error("pin driven while disabled");

    a_pin_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !in_idle |-> (pulse_out_pin_b_oe == pinsel_ff) && (pulse_out_pin_a_oe != pinsel_ff))
        else $error("output routed to wrong pin");

    a_start_lead: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start_wr |=> in_lead ##1 !out_level_ff)
        else $error("enable write did not restart into lead");

    a_lead_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_lead |=> !out_level_ff)
        else $error("pin high during lead phase");

    a_lead_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start_wr && css_new |=> lead_cnt_ff == {1'b0, presc_act_ff} + LEAD_ONE)
        else $error("lead length wrong at full rate");

    a_first_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(in_run) && duty_act_ff != VAL_ZERO |=> out_level_ff)
        else $error("first pulse did not start high");

    a_duty_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_run && duty_act_ff == VAL_ZERO |=> !out_level_ff)
        else $error("zero duty produced a high level");

    a_shadow_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_run && !core.period_end && !start_wr |=> $stable(duty_act_ff) && $stable(presc_act_ff))
        else $error("values changed inside a period");

    a_lead_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lead_done && !wr_ctrl |=> in_run)
        else $error("lead phase overran");
endmodule
`default_nettype wire

//--- pwmp_load.sv
`timescale 1ns/1ps
`default_nettype none
// external load on the two shared port pins
// each pin carries a weak pull-up, so a released pin reads high
// and can never be mistaken for a driven low level
module pwmp_load (
    input  wire logic pin_a_o,
    input  wire logic pin_a_oe,
    input  wire logic pin_b_o,
    input  wire logic pin_b_oe,
    output wire logic lvl_a,
    output wire logic lvl_b
);
    // a driven level wins, otherwise the pull-up shows
    assign lvl_a = pin_a_oe ? pin_a_o : 1'b1;
    assign lvl_b = pin_b_oe ? pin_b_o : 1'b1;
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pwmp_pkg::*;
    logic              clk_sys;     // 100 MHz system clock
    logic              reset_n;     // async reset, active low
    logic              psel;        // apb select
    logic              penable;     // apb access phase
    logic              pwrite;      // apb direction
    logic [ADDR_W-1:0] paddr;       // apb byte address
    logic [DATA_W-1:0] pwdata;      // apb write data
    logic [DATA_W-1:0] prdata;      // apb read data
    wire logic         pready;      // apb ready
    wire logic         pslverr;     // apb error
    wire logic         a_o;         // pin a level
    wire logic         a_oe;        // pin a enable
    wire logic         b_o;         // pin b level
    wire logic         b_oe;        // pin b enable
    wire logic         lvl_a;       // pin a as the load sees it
    wire logic         lvl_b;       // pin b as the load sees it
    logic              sel_b;       // which pin the tests watch
    wire logic         pin_lvl;     // level of the watched pin
    int                mismatches;  // failed comparisons
    int                comparisons; // all comparisons

    pwmp_top i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pulse_out_pin_a_o(a_o), .pulse_out_pin_a_oe(a_oe),
        .pulse_out_pin_b_o(b_o), .pulse_out_pin_b_oe(b_oe)
    );

    pwmp_load i_load (
        .pin_a_o(a_o), .pin_a_oe(a_oe), .pin_b_o(b_o), .pin_b_oe(b_oe),
        .lvl_a(lvl_a), .lvl_b(lvl_b)
    );

    assign pin_lvl = sel_b ? lvl_b : lvl_a;

    // free-running clock
    always #5 clk_sys = ~clk_sys;

    // compare one value, count it, report a difference at once
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wd,
                       output logic [DATA_W-1:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // plain register write, returns at the edge where it is taken
    task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wd);
        logic [DATA_W-1:0] rd;
        logic              err;
        apb(1'b1, addr, wd, rd, err);
    endtask

    // length of the current run of the watched pin, in clocks
    task automatic next_run(input int limit, output int len);
        logic l0;
        #1;
        l0 = pin_lvl;
        len = 0;
        while (pin_lvl === l0 && len < limit) begin
            @(posedge clk_sys);
            #1;
            len++;
        end
    endtask

    // program values while idle, then enable on the chosen pin
    task automatic start(input logic css, input logic [7:0] n, input logic [7:0] m, input logic pin);
        wr(REG_CTRL_OFS, 32'h0);
        wr(REG_PRESC_OFS, {24'h0, n});
        wr(REG_DUTY_OFS, {24'h0, m});
        sel_b = pin;
        wr(REG_CTRL_OFS, {29'h0, pin, css, 1'b1});
    endtask

    // reset values, masking of upper bits, unmapped access
    task automatic test_regs();
        logic [DATA_W-1:0] rd;
        logic              err;
        check("oe a idle", a_oe, 1'b0);
        check("oe b idle", b_oe, 1'b0);
        check("pready", pready, 1'b1);
        apb(1'b0, REG_CTRL_OFS, 32'h0, rd, err);
        check("ctrl reset", rd, 32'h0);
        wr(REG_PRESC_OFS, 32'hffff_ff5a);
        apb(1'b0, REG_PRESC_OFS, 32'h0, rd, err);
        check("presc readback", rd, 32'h5a);
        apb(1'b0, 12'h010, 32'h0, rd, err);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        $display("test_regs done");
    endtask

    // lead, high and low lengths for one setting
    task automatic test_wave(input logic css, input int n, input int m, input logic pin);
        int k;
        int len;
        k = css ? 1 : 2;
        start(css, n[7:0], m[7:0], pin);
        next_run(3000, len);
        check("lead low", len, css ? n + 2 : (n + 2) / 2 + 1);
        check("oe chosen", pin ? b_oe : a_oe, 1'b1);
        check("oe other", pin ? a_oe : b_oe, 1'b0);
        next_run(3000, len);
        check("high", len, m * (n + 1) * k);
        next_run(3000, len);
        check("low", len, (255 - m) * (n + 1) * k);
        next_run(3000, len);
        check("high again", len, m * (n + 1) * k);
        // stopping releases both pins at once
        wr(REG_CTRL_OFS, 32'h0);
        @(posedge clk_sys);
        #1;
        check("oe a off", a_oe, 1'b0);
        check("oe b off", b_oe, 1'b0);
        $display("test_wave done css %0d n %0d m %0d pin %0d", css, n, m, pin);
    endtask

    // duty 0 never rises, duty 255 never falls after the lead
    task automatic test_const();
        int                len;
        logic [DATA_W-1:0] rd;
        logic              err;
        start(1'b1, 8'h00, VAL_ZERO, 1'b0);
        next_run(600, len);
        check("duty zero low", len, 600);
        start(1'b1, 8'h00, DUTY_FULL, 1'b1);
        next_run(600, len);
        check("duty full lead", len, 2);
        next_run(600, len);
        check("duty full high", len, 600);
        // status while running high: run bit and level bit set
        apb(1'b0, REG_STAT_OFS, 32'h0, rd, err);
        check("stat running high", rd, 32'h5);
        // enable written again while running restarts with a low lead
        wr(REG_CTRL_OFS, 32'h7);
        next_run(600, len);
        check("restart lead", len, 2);
        wr(REG_CTRL_OFS, 32'h0);
        $display("test_const done");
    endtask

    // writes in mid-period only apply from the next period
    task automatic test_update();
        int len;
        start(1'b1, 8'h00, 8'h0a, 1'b0);
        next_run(3000, len);
        wr(REG_DUTY_OFS, 32'h14);
        next_run(3000, len);
        check("old duty high rest", len, 7);
        next_run(3000, len);
        check("old duty low", len, 245);
        wr(REG_PRESC_OFS, 32'h01);
        next_run(3000, len);
        check("new duty high rest", len, 17);
        next_run(3000, len);
        check("old presc low", len, 235);
        next_run(3000, len);
        check("new presc high", len, 40);
        wr(REG_CTRL_OFS, 32'h0);
        $display("test_update done");
    endtask

    // summary and verdict, the only place the run ends
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watchdog, well beyond the roughly 6000 clocks the tests need
    initial begin
        #200_000;
        mismatches++;
        $display("watchdog expired");
        print_verdict();
    end

    // main sequence
    initial begin
        clk_sys = 1'b0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        sel_b = 1'b0;
        mismatches = 0;
        comparisons = 0;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        test_regs();
        test_wave(1'b1, 0, 2, 1'b0);
        test_wave(1'b0, 2, 5, 1'b1);
        test_wave(1'b1, 3, 254, 1'b0);
        test_const();
        test_update();
        print_verdict();
    end
endmodule
`default_nettype wire
